// ===== verilog/lps_defines.svh
// Constants of the light and proximity sensor two-wire slave
`ifndef LPS_DEFINES_SVH
`define LPS_DEFINES_SVH

// ****************************************
// Bus address and timing
// ****************************************
`define LPS_SLAVE_ADDR 7'h1E
`define LPS_CLK_PERIOD_NS 25
`define LPS_SPIKE_NS 50
// Stable for one sample longer than the widest spike
`define LPS_SPIKE_CYC ((`LPS_SPIKE_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS + 1)
`define LPS_SRST_MS 10
`define LPS_SRST_CYC (`LPS_SRST_MS * 1000000 / `LPS_CLK_PERIOD_NS)

// ****************************************
// Register offsets
// ****************************************
`define LPS_REG_SYS_CFG 8'h00
`define LPS_REG_INT_STAT 8'h01
`define LPS_REG_CLR_METHOD 8'h02
`define LPS_REG_IR_LO 8'h0A
`define LPS_REG_IR_HI 8'h0B
`define LPS_REG_ALS_LO 8'h0C
`define LPS_REG_ALS_HI 8'h0D
`define LPS_REG_PROX_LO 8'h0E
`define LPS_REG_PROX_HI 8'h0F
`define LPS_REG_ALS_CFG 8'h10

// ****************************************
// Fields and reset values
// ****************************************
`define LPS_ALS_RANGE_LSB 4
`define LPS_ALS_RANGE_WIDEST 2'h0
`define LPS_MODE_POWER_DOWN 3'h0
`define LPS_MODE_SOFT_RESET 3'h4
`define LPS_STAT_ALS_BIT 0
`define LPS_STAT_PROX_BIT 1

`endif

// ===== verilog/lps_pkg.sv
// Types of the light and proximity sensor two-wire slave
package lps_pkg;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_AACK = 10'h004,
    ST_REGA = 10'h008,
    ST_RACK = 10'h010,
    ST_WDAT = 10'h020,
    ST_WACK = 10'h040,
    ST_RDAT = 10'h080,
    ST_MACK = 10'h100,
    ST_SKIP = 10'h200
  } lps_state_type;

  typedef struct packed {
    logic [15:0] als_count;
    logic [9:0] prox_count;
    logic [9:0] ir_count;
    logic als_done;
    logic prox_done;
    logic als_event;
    logic prox_event;
  } lps_meas_type;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] als_range;
    logic clear_method;
  } lps_cfg_type;

endpackage : lps_pkg

// ===== verilog/lps_pin_filter.sv
// Pin synchroniser with spike filter
`timescale 1ns/100ps
module lps_pin_filter #(
  parameter int CYC = 3,
  parameter logic INIT = 1'b1
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n,  // Asynchronous reset, active low
  input wire logic pin,     // Raw pin level
  output logic level        // Filtered level
);
  logic s1;
  logic s2;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_level;

  always_comb begin
    next_cnt = 4'h0;
    next_level = level;
    // Level only follows after the new value held for CYC samples
    if (s2 != level) begin
      if (cnt == 4'(CYC - 1)) begin
        next_level = s2; // R06
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      cnt <= 4'h0;
      level <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      cnt <= next_cnt;
      level <= next_level;
    end
  end

  AST_SPIKE_SUPPRESSED: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
    (level != $past(level)) |-> ($past(s2, 1) == level && $past(s2, 2) == level
      && $past(s2, 3) == level))
    else $error("filtered level changed without stable input");

endmodule : lps_pin_filter

// ===== verilog/lps_sensor_slave.sv
// Two-wire slave and register logic of the light and proximity sensor
`timescale 1ns/100ps
`include "lps_defines.svh"

// Contract
// R01: Write frame: address, register, data, each acknowledged
// R02: Combined read: register address, repeated start, one byte
// R03: Master not-acknowledges read byte, then stops
// R04: Receiver acknowledges by pulling data low
// R05: Direction bit zero writes, one reads
// R06: Spikes up to 50 ns are ignored
// R07: Light count is unsigned 16 bits
// R08: Proximity count is unsigned 10 bits
// R09: Four light ranges, widest after reset
// R10: Brown-out resets all logic and registers
// R11: Host rewrites configuration after brown-out
// R12: Foreign address gets no acknowledge, frame ignored
// R13: Slave answers bus address 0x1E
// R14: Three-bit mode encoding, power down at reset
// R15: Light or proximity event pulls interrupt low
// R16: Clear by data read or by write one
module lps_sensor_slave #(
  parameter int SRST_CYC = `LPS_SRST_CYC
) (
  input wire logic sys_clk,                  // System clock, 40 MHz
  input wire logic arst_n,                   // Power-on reset, active low
  input wire logic scl_pin,                  // Serial clock pin
  input wire logic sda_pin,                  // Serial data pin level
  output logic sda_o,                        // Serial data output value
  output logic sda_oe,                       // High while pulling data low
  input wire logic supply_low_pin,           // Brown-out detector output
  input wire lps_pkg::lps_meas_type meas,    // Converter results and events
  output lps_pkg::lps_cfg_type cfg,          // Configuration to the sensor core
  output logic int_n                         // Interrupt, active low
);
  // ****************************************
  // Pin conditioning
  // ****************************************
  logic scl;
  logic sda;
  logic brown;
  logic scl_q;
  logic sda_q;

  lps_pin_filter #(.CYC(`LPS_SPIKE_CYC), .INIT(1'b1)) u_scl_filt (
    .sys_clk(sys_clk), .arst_n(arst_n), .pin(scl_pin), .level(scl));
  lps_pin_filter #(.CYC(`LPS_SPIKE_CYC), .INIT(1'b1)) u_sda_filt (
    .sys_clk(sys_clk), .arst_n(arst_n), .pin(sda_pin), .level(sda));
  lps_pin_filter #(.CYC(`LPS_SPIKE_CYC), .INIT(1'b0)) u_brown_filt (
    .sys_clk(sys_clk), .arst_n(arst_n), .pin(supply_low_pin), .level(brown));

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_cond = scl & scl_q & sda_q & ~sda;
  wire stop_cond = scl & scl_q & ~sda_q & sda;

  // ****************************************
  // Link state
  // ****************************************
  lps_pkg::lps_state_type state;
  lps_pkg::lps_state_type next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic next_sda_oe;
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] rd_addr;
  logic [7:0] rd_byte;
  logic clr_all;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_ptr = ptr;
    next_rw = rw;
    next_sda_oe = sda_oe;
    wr_pulse = 1'b0;
    rd_pulse = 1'b0;
    rd_addr = ptr;
    if (clr_all) begin
      next_state = lps_pkg::ST_IDLE;
      next_bitcnt = 4'h0;
      next_sh = 8'h00;
      next_ptr = 8'h00;
      next_rw = 1'b0;
      next_sda_oe = 1'b0;
    end else if (start_cond) begin
      // Repeated start lands here too and keeps the register pointer
      next_state = lps_pkg::ST_ADDR; // R02
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_state = lps_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        lps_pkg::ST_IDLE, lps_pkg::ST_SKIP: begin
        end
        lps_pkg::ST_ADDR, lps_pkg::ST_REGA, lps_pkg::ST_WDAT: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            if (state == lps_pkg::ST_ADDR) begin
              if (sh[7:1] == `LPS_SLAVE_ADDR) begin // R13
                next_state = lps_pkg::ST_AACK;
                next_sda_oe = 1'b1; // R04
                next_rw = sh[0]; // R05
              end else begin
                next_state = lps_pkg::ST_SKIP; // R12
              end
            end else if (state == lps_pkg::ST_REGA) begin
              next_ptr = sh;
              next_state = lps_pkg::ST_RACK;
              next_sda_oe = 1'b1; // R01
            end else begin
              wr_pulse = 1'b1; // R01
              next_ptr = ptr + 8'h01;
              next_state = lps_pkg::ST_WACK;
              next_sda_oe = 1'b1;
            end
          end
        end
        lps_pkg::ST_AACK, lps_pkg::ST_RACK, lps_pkg::ST_WACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            if (state == lps_pkg::ST_AACK && rw) begin
              rd_pulse = 1'b1; // R02
              next_sh = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_ptr = ptr + 8'h01;
              next_state = lps_pkg::ST_RDAT;
            end else if (state == lps_pkg::ST_AACK) begin
              next_state = lps_pkg::ST_REGA;
            end else begin
              next_state = lps_pkg::ST_WDAT;
            end
          end
        end
        lps_pkg::ST_RDAT: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_sda_oe = 1'b0;
              next_state = lps_pkg::ST_MACK;
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];
            end
          end
        end
        lps_pkg::ST_MACK: begin
          if (scl_rise && sda) begin
            next_state = lps_pkg::ST_SKIP; // R03
          end else if (scl_fall) begin
            // Master asked for more: stream the next register
            rd_pulse = 1'b1;
            next_sh = rd_byte;
            next_sda_oe = ~rd_byte[7];
            next_ptr = ptr + 8'h01;
            next_bitcnt = 4'h0;
            next_state = lps_pkg::ST_RDAT;
          end
        end
        default: begin
          next_state = lps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= lps_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      ptr <= next_ptr;
      rw <= next_rw;
      sda_oe <= next_sda_oe;
      sda_o <= 1'b0;
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0] als_data;
  logic [15:0] next_als_data;
  logic [9:0] prox_data;
  logic [9:0] next_prox_data;
  logic [9:0] ir_data;
  logic [9:0] next_ir_data;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [1:0] got;
  logic [1:0] next_got;
  logic [22:0] srst_cnt;
  logic [22:0] next_srst_cnt;
  lps_pkg::lps_cfg_type next_cfg;
  logic [1:0] stat_clr;
  logic als_on;
  logic prox_on;

  assign clr_all = brown | (srst_cnt == 23'h000001); // R10

  always_comb begin
    unique case (rd_addr)
      `LPS_REG_SYS_CFG: rd_byte = {5'h00, cfg.mode};
      `LPS_REG_INT_STAT: rd_byte = {6'h00, status};
      `LPS_REG_CLR_METHOD: rd_byte = {7'h00, cfg.clear_method};
      `LPS_REG_IR_LO: rd_byte = {6'h00, ir_data[1:0]};
      `LPS_REG_IR_HI: rd_byte = ir_data[9:2];
      `LPS_REG_ALS_LO: rd_byte = als_data[7:0];
      `LPS_REG_ALS_HI: rd_byte = als_data[15:8];
      `LPS_REG_PROX_LO: rd_byte = {4'h0, prox_data[3:0]};
      `LPS_REG_PROX_HI: rd_byte = {2'h0, prox_data[9:4]};
      `LPS_REG_ALS_CFG: rd_byte = {2'h0, cfg.als_range, 4'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_cfg = cfg;
    next_als_data = als_data;
    next_prox_data = prox_data;
    next_ir_data = ir_data;
    next_got = got;
    next_srst_cnt = (srst_cnt != 23'h000000) ? srst_cnt - 23'h000001 : srst_cnt;
    stat_clr = 2'h0;
    // Soft reset code drives no channel
    als_on = cfg.mode[0] & (cfg.mode != `LPS_MODE_SOFT_RESET); // R14
    prox_on = cfg.mode[1];
    if (als_on && meas.als_done) begin
      next_als_data = meas.als_count; // R07
      next_got[0] = 1'b1;
    end
    if (prox_on && meas.prox_done) begin
      next_prox_data = meas.prox_count; // R08
      next_ir_data = meas.ir_count;
      next_got[1] = 1'b1;
    end
    // Single-shot modes drop to power down once every wanted channel reported
    if (cfg.mode[2] && cfg.mode != `LPS_MODE_SOFT_RESET
        && (next_got & cfg.mode[1:0]) == cfg.mode[1:0]) begin
      next_cfg.mode = `LPS_MODE_POWER_DOWN; // R14
    end
    if (rd_pulse && !cfg.clear_method) begin
      stat_clr[`LPS_STAT_ALS_BIT] = (rd_addr == `LPS_REG_ALS_HI); // R16
      stat_clr[`LPS_STAT_PROX_BIT] = (rd_addr == `LPS_REG_PROX_HI);
    end
    if (wr_pulse) begin
      unique case (ptr)
        `LPS_REG_SYS_CFG: begin
          next_cfg.mode = sh[2:0]; // R14
          next_got = 2'h0;
          if (sh[2:0] == `LPS_MODE_POWER_DOWN) begin
            next_als_data = 16'h0000;
            next_prox_data = 10'h000;
            next_ir_data = 10'h000;
          end
          if (sh[2:0] == `LPS_MODE_SOFT_RESET) begin
            next_srst_cnt = 23'(SRST_CYC); // R14
          end
        end
        `LPS_REG_INT_STAT: begin
          if (cfg.clear_method) begin
            stat_clr = sh[1:0]; // R16
          end
        end
        `LPS_REG_CLR_METHOD: next_cfg.clear_method = sh[0];
        `LPS_REG_ALS_CFG: next_cfg.als_range = sh[`LPS_ALS_RANGE_LSB +: 2]; // R09
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives
    next_status = (status & ~stat_clr) | {meas.prox_event, meas.als_event}; // R15
    if (clr_all) begin
      next_cfg = '{mode: `LPS_MODE_POWER_DOWN, als_range: `LPS_ALS_RANGE_WIDEST,
                   clear_method: 1'b0}; // R09
      next_als_data = 16'h0000;
      next_prox_data = 10'h000;
      next_ir_data = 10'h000;
      next_got = 2'h0;
      next_status = 2'h0;
      next_srst_cnt = 23'h000000;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{mode: `LPS_MODE_POWER_DOWN, als_range: `LPS_ALS_RANGE_WIDEST,
               clear_method: 1'b0};
      als_data <= 16'h0000;
      prox_data <= 10'h000;
      ir_data <= 10'h000;
      got <= 2'h0;
      status <= 2'h0;
      srst_cnt <= 23'h000000;
      int_n <= 1'b1;
    end else begin
      cfg <= next_cfg;
      als_data <= next_als_data;
      prox_data <= next_prox_data;
      ir_data <= next_ir_data;
      got <= next_got;
      status <= next_status;
      srst_cnt <= next_srst_cnt;
      int_n <= ~|next_status; // R15
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_ADDR_MATCH_ACK: assert property (@(posedge sys_clk) disable iff (!arst_n) // R13
    (!clr_all && !start_cond && !stop_cond && state == lps_pkg::ST_ADDR && scl_fall
      && bitcnt == 4'h8 && sh[7:1] == `LPS_SLAVE_ADDR)
      |=> (state == lps_pkg::ST_AACK && sda_oe))
    else $error("own address not acknowledged");

  AST_FOREIGN_NO_ACK: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
    (!clr_all && !start_cond && !stop_cond && state == lps_pkg::ST_ADDR && scl_fall
      && bitcnt == 4'h8 && sh[7:1] != `LPS_SLAVE_ADDR)
      |=> (state == lps_pkg::ST_SKIP && !sda_oe))
    else $error("foreign address acknowledged");

  AST_DIRECTION: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
    (!clr_all && !start_cond && !stop_cond && state == lps_pkg::ST_AACK && scl_fall)
      |=> (rw ? state == lps_pkg::ST_RDAT : state == lps_pkg::ST_REGA))
    else $error("direction bit not honoured");

  AST_ACK_HELD: assert property (@(posedge sys_clk) disable iff (!arst_n) // R04
    (state == lps_pkg::ST_RACK || state == lps_pkg::ST_WACK) |-> sda_oe)
    else $error("acknowledge slot released early");

  AST_MASTER_NACK: assert property (@(posedge sys_clk) disable iff (!arst_n) // R03
    (!clr_all && !start_cond && !stop_cond && state == lps_pkg::ST_MACK && scl_rise && sda)
      |=> (state == lps_pkg::ST_SKIP) ##1 !sda_oe)
    else $error("read continued after not-acknowledge");

  AST_BROWN_RESET: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
    brown |=> (cfg.mode == `LPS_MODE_POWER_DOWN && cfg.als_range == `LPS_ALS_RANGE_WIDEST
      && status == 2'h0 && state == lps_pkg::ST_IDLE))
    else $error("brown-out did not reset state");

  AST_EVENT_INT: assert property (@(posedge sys_clk) disable iff (!arst_n) // R15
    (!clr_all && (meas.als_event || meas.prox_event)) |=> (!int_n && status != 2'h0))
    else $error("event did not raise interrupt");

  AST_W1C_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n) // R16
    (!clr_all && wr_pulse && ptr == `LPS_REG_INT_STAT && cfg.clear_method
      && !meas.als_event && !meas.prox_event) |=> ((status & $past(sh[1:0])) == 2'h0))
    else $error("write one did not clear status");

endmodule : lps_sensor_slave

// ===== test/lps_host_model.sv
// Two-wire bus master model that drives the sensor slave
`timescale 1ns/100ps
`include "lps_defines.svh"
module lps_host_model (
  input wire logic sys_clk, // System clock, outputs change on its fall
  input wire logic sda,     // Resolved data wire
  output logic scl,         // Serial clock
  output logic sda_m        // Master data, high means released
);
  logic spike;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    spike = 1'b0;
  end
  // ****
  // Bit level
  // ****
  task automatic half_bit();
    repeat (16) @(negedge sys_clk);
  endtask : half_bit
  task automatic clk_bit(input logic b, output logic seen);
    sda_m = b;
    half_bit();
    scl = 1'b1;
    if (spike) begin
      repeat (6) @(negedge sys_clk);
      scl = 1'b0; // Two-cycle dip that the slave must not count as a clock
      repeat (2) @(negedge sys_clk);
      scl = 1'b1;
    end
    half_bit();
    seen = sda;
    scl = 1'b0;
  endtask : clk_bit
  task automatic start();
    sda_m = 1'b1;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_m = 1'b0;
    half_bit();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_m = 1'b1;
    half_bit();
  endtask : stop
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack);
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, s);
  endtask : recv_byte
  // ****
  // Frames
  // ****
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic [2:0] acks);
    start();
    send_byte({dev, 1'b0}, acks[2]);
    send_byte(ra, acks[1]);
    send_byte(d, acks[0]);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d, output logic [2:0] acks);
    start();
    send_byte({`LPS_SLAVE_ADDR, 1'b0}, acks[2]);
    send_byte(ra, acks[1]);
    start();
    send_byte({`LPS_SLAVE_ADDR, 1'b1}, acks[0]);
    recv_byte(1'b1, d);
    stop();
  endtask : read_reg
endmodule : lps_host_model

// ===== test/lps_sensor_slave_tb.sv
// Self-checking testbench of the light and proximity sensor slave
`timescale 1ns/100ps
`include "lps_defines.svh"
module lps_sensor_slave_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_low_pin = 1'b0;
  lps_pkg::lps_meas_type meas = '0;
  lps_pkg::lps_cfg_type cfg;
  logic sda_o, sda_oe, int_n, scl, sda_m, sda;
  int miscompares = 0;
  int num_checks = 0;
  // Pull-up wire: anyone driving low wins
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  lps_sensor_slave #(.SRST_CYC(200)) lps_sensor_slave_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .scl_pin(scl), .sda_pin(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .supply_low_pin(supply_low_pin), .meas(meas), .cfg(cfg), .int_n(int_n));
  lps_host_model lps_host_model_i (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ****
  // Helpers
  // ****
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [2:0] a;
    lps_host_model_i.write_reg(`LPS_SLAVE_ADDR, ra, d, a);
    chk8("write acks", 8'h00, {5'h00, a});
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] d;
    logic [2:0] a;
    lps_host_model_i.read_reg(ra, d, a);
    chk8("read acks", 8'h00, {5'h00, a});
    chk8("read data", exp, d);
  endtask : rd
  // Bit order is {als_done, prox_done, als_event, prox_event}
  task automatic pulse(input logic [3:0] p);
    meas[3:0] = p;
    @(negedge sys_clk);
    meas[3:0] = 4'h0;
    @(negedge sys_clk);
  endtask : pulse
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // ****
  // Scenarios
  // ****
  task automatic test_reset();
    chk8("cfg", 8'h00, {2'h0, cfg});
    chk_bit("int_n", 1'b1, int_n);
    chk_bit("sda_oe", 1'b0, sda_oe);
  endtask : test_reset
  task automatic test_ranges();
    for (int r = 3; r >= 0; r--) begin
      wr(`LPS_REG_ALS_CFG, 8'(r << 4));
      chk8("range", 8'(r), {6'h00, cfg.als_range});
      rd(`LPS_REG_ALS_CFG, 8'(r << 4));
    end
  endtask : test_ranges
  task automatic test_modes();
    logic [2:0] a;
    for (int m = 7; m >= 0; m--) begin
      if (m != 4) begin
        wr(`LPS_REG_SYS_CFG, 8'(m));
        chk8("mode", 8'(m), {5'h00, cfg.mode});
      end
    end
    wr(`LPS_REG_ALS_CFG, 8'h20);
    // Soft reset lands only after the frame has ended, so all acks arrive
    lps_host_model_i.write_reg(`LPS_SLAVE_ADDR, `LPS_REG_SYS_CFG, 8'h04, a);
    chk8("soft reset acks", 8'h00, {5'h00, a});
    repeat (300) @(negedge sys_clk);
    chk8("cfg after soft reset", 8'h00, {2'h0, cfg});
  endtask : test_modes
  task automatic test_data();
    wr(`LPS_REG_SYS_CFG, 8'h03);
    meas.als_count = 16'hFFFF;
    meas.prox_count = 10'h3FF;
    meas.ir_count = 10'h2AA;
    pulse(4'hC);
    rd(`LPS_REG_ALS_LO, 8'hFF);
    rd(`LPS_REG_ALS_HI, 8'hFF);
    rd(`LPS_REG_PROX_HI, 8'h3F);
    rd(`LPS_REG_PROX_LO, 8'h0F);
    rd(`LPS_REG_IR_HI, 8'hAA);
    rd(`LPS_REG_IR_LO, 8'h02);
    rd(8'h05, 8'h00);
    wr(`LPS_REG_SYS_CFG, 8'h05);
    meas.als_count = 16'h1234;
    pulse(4'h8);
    chk8("mode after one shot", 8'h00, {5'h00, cfg.mode});
    rd(`LPS_REG_ALS_LO, 8'h34);
  endtask : test_data
  task automatic test_irq();
    pulse(4'h2);
    chk_bit("int_n", 1'b0, int_n);
    rd(`LPS_REG_INT_STAT, 8'h01);
    rd(`LPS_REG_ALS_HI, 8'h12);
    chk_bit("int_n", 1'b1, int_n);
    wr(`LPS_REG_CLR_METHOD, 8'h01);
    pulse(4'h1);
    rd(`LPS_REG_PROX_HI, 8'h3F);
    chk_bit("int_n", 1'b0, int_n);
    rd(`LPS_REG_INT_STAT, 8'h02);
    wr(`LPS_REG_INT_STAT, 8'h02);
    chk_bit("int_n", 1'b1, int_n);
    rd(`LPS_REG_INT_STAT, 8'h00);
  endtask : test_irq
  task automatic test_foreign();
    logic [2:0] a;
    lps_host_model_i.write_reg(7'h1F, `LPS_REG_ALS_CFG, 8'h30, a);
    chk8("foreign acks", 8'h07, {5'h00, a});
    chk8("range", 8'h00, {6'h00, cfg.als_range});
  endtask : test_foreign
  task automatic test_spike();
    lps_host_model_i.spike = 1'b1;
    wr(`LPS_REG_ALS_CFG, 8'h30);
    lps_host_model_i.spike = 1'b0;
    chk8("range", 8'h03, {6'h00, cfg.als_range});
  endtask : test_spike
  task automatic test_brownout();
    supply_low_pin = 1'b1;
    repeat (10) @(negedge sys_clk);
    supply_low_pin = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk8("cfg", 8'h00, {2'h0, cfg});
    rd(`LPS_REG_CLR_METHOD, 8'h00);
    wr(`LPS_REG_ALS_CFG, 8'h10);
    chk8("range", 8'h01, {6'h00, cfg.als_range});
  endtask : test_brownout
  // Whole run needs about 1.1 ms of bus traffic
  initial begin
    #2000000;
    miscompares++;
    results();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    test_reset();
    test_ranges();
    test_modes();
    test_data();
    test_irq();
    test_foreign();
    test_spike();
    test_brownout();
    results();
  end
endmodule : lps_sensor_slave_tb
